// [hdl/csu_pkg.sv]
// Shared constants, register map and carrier types for the charger status logic
package csu_pkg;

  localparam int unsigned CLK_KHZ = 250000;
  localparam int unsigned DEGLITCH_MS = 8;
  localparam int unsigned DEGLITCH_CYC = DEGLITCH_MS * CLK_KHZ;
  localparam int unsigned ALERT_MIN_MS = 6;
  localparam int unsigned ALERT_MAX_MS = 10;
  localparam int unsigned ALERT_CYC = ((ALERT_MIN_MS + ALERT_MAX_MS) / 2) * CLK_KHZ;
  localparam int unsigned TMR_W = 21;

  localparam logic [7:0] IDX_CTRL = 8'h12;
  localparam logic [7:0] IDX_STAT = 8'h13;
  localparam logic [7:0] IDX_VCHG = 8'h15;
  localparam logic [31:0] ADDR_CTRL = {22'h000000, IDX_CTRL, 2'h0};
  localparam logic [31:0] ADDR_STAT = {22'h000000, IDX_STAT, 2'h0};
  localparam logic [31:0] ADDR_VCHG = {22'h000000, IDX_VCHG, 2'h0};

  localparam int unsigned CTRL_LEARN_BIT = 4;
  localparam int unsigned CTRL_DEP_LSB = 9;
  localparam int unsigned CTRL_DEP_W = 3;
  localparam int unsigned STAT_DEP_BIT = 11;
  localparam int unsigned STAT_VOR_BIT = 12;
  localparam int unsigned STAT_REV_BIT = 13;
  localparam int unsigned STAT_BAT_BIT = 14;
  localparam int unsigned STAT_AC_BIT = 15;

  localparam logic [15:0] CTRL_RST = 16'h0000;
  localparam logic [15:0] VCHG_RST = 16'h0000;

  localparam logic [15:0] VCHG_WAKE_MV = 16'h2328;
  localparam logic [15:0] VCHG_LO_MIN_MV = 16'h2EE0;
  localparam logic [15:0] VCHG_LO_MAX_MV = 16'h3840;
  localparam logic [15:0] VCHG_HI_MIN_MV = 16'h3E80;
  localparam logic [15:0] VCHG_HI_MAX_MV = 16'h4B00;
  localparam logic [15:0] VCHG_STEP_MASK = 16'h000F;
  localparam logic [15:0] DEP_BASE_MV = 16'h0AF0;
  localparam logic [15:0] DEP_STEP_MV = 16'h0064;
  localparam logic [15:0] CELLS_LO = 16'h0003;
  localparam logic [15:0] CELLS_HI = 16'h0004;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef struct packed {
    logic [31:0] awaddr;
    logic awvalid;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic wvalid;
    logic bready;
    logic [31:0] araddr;
    logic arvalid;
    logic rready;
  } csu_axil_req_t;

  typedef struct packed {
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } csu_axil_rsp_t;

  // Comparator levels from the analog front end, all asynchronous
  typedef struct packed {
    logic battery_depleted;
    logic battery_above_adapter;
    logic input_margin_low;
    logic input_margin_high;
    logic battery_present;
    logic adapter_detected;
    logic adapter_wake;
    logic supply_ok;
  } csu_cmp_t;

  typedef struct packed {
    logic battery_switch_drive;
    logic adapter_switch_drive;
    logic bypass_switch_drive;
    logic charge_enable;
    logic five_volt_reference_output;
    logic gate_drive_regulator;
    logic alert;
  } csu_drv_t;

  typedef struct packed {
    logic [15:0] target;
    logic enable;
    logic out_of_range;
  } csu_vdec_t;

endpackage

// [hdl/csu_deglitch.sv]
// Qualifies a level once it has stayed high for a full deglitch window
`timescale 1ns/1ps
module csu_deglitch #(
  parameter int unsigned CYC = csu_pkg::DEGLITCH_CYC
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic level,
  output logic qual
);
  import csu_pkg::*;

  typedef struct packed {
    logic [TMR_W-1:0] cnt;
    logic qual;
  } csu_dgl_st_t;

  csu_dgl_st_t st_q;
  csu_dgl_st_t st_d;

  always_comb begin
    st_d = st_q;
    if (!level) begin
      // Drop is immediate, only the rise is filtered
      st_d.cnt = '0;
      st_d.qual = 1'b0;
    end else if (!st_q.qual) begin
      if (st_q.cnt == TMR_W'(CYC - 1)) begin
        st_d.qual = 1'b1;
      end else begin
        st_d.cnt = st_q.cnt + TMR_W'(1);
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign qual = st_q.qual;

  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);

  a_dgl_rise: assert property ($rose(st_q.qual) |-> $past(st_q.cnt) == TMR_W'(CYC - 1) && $past(level)) // (R10)
    else $error("deglitch qualified before full window");
  a_dgl_drop: assert property (!level |=> !st_q.qual) // (R10)
    else $error("deglitch output held after level fell");

endmodule

// [hdl/csu_flags.sv]
// Charger status upper flags, switch drives, charge gating and alert, behind an AXI4-Lite slave
// What this block does
// (R1) Status bit 11 high while battery is below the depleted threshold.
// (R2) Depleted threshold is control bits 9-11 per cell, times 3 or 4 cells.
// (R3) Depleted battery turns battery switch off; adapter switch on if learning with adapter.
// (R4) Status bit 12 high when the charge-voltage setting is outside the valid range.
// (R5) Accept 9 V, 12-14.4 V, 16-19.2 V; round settings down to a converter step.
// (R6) Setting above 19.2 V keeps charging on, regulating at 19.2 V.
// (R7) Below 12 V (not 9 V) or 14.4-16 V: disable charge, flag, alert host.
// (R8) The 9000 mV code regulates to 9 V for battery wake-up.
// (R9) Status bit 13 high while battery sense exceeds adapter sense.
// (R10) Bypass switch off at once under 150 mV margin; back on after 8 ms deglitch.
// (R11) Status bit 14 high while thermistor sense is below battery-detect threshold.
// (R12) Charging stops at once by itself when no battery is detected.
// (R13) Status bit 15 high while adapter detect is above 2.4 V.
// (R14) Charging and the 5 V reference stay off until the adapter is detected.
// (R15) Power-on and bus traffic start only with adapter wake and supply good.
// (R16) Alert rises 6 to 10 ms after any status bit toggles.
// (R17) Status bits are read-only; reads give current condition, writes are ignored.
//
// Local design decisions: the register offsets and register access over AXI4-Lite.
`timescale 1ns/1ps
module csu_flags #(
  parameter int unsigned DEGLITCH_CYC = csu_pkg::DEGLITCH_CYC,
  parameter int unsigned ALERT_CYC = csu_pkg::ALERT_CYC
) (
  input wire logic aclk,
  input wire logic aresetn,
  input csu_pkg::csu_axil_req_t s_axi_req,
  output csu_pkg::csu_axil_rsp_t s_axi_rsp,
  input csu_pkg::csu_cmp_t cmp_i,
  output csu_pkg::csu_drv_t drv_o,
  output logic [15:0] charge_target_mv,
  output logic [15:0] battery_depleted_threshold
);
  import csu_pkg::*;

  typedef enum logic [2:0] {
    AL_IDLE = 3'h1,
    AL_WAIT = 3'h2,
    AL_ON = 3'h4
  } csu_alert_st_t;

  typedef struct packed {
    csu_cmp_t s1;
    csu_cmp_t s2;
    logic [15:0] ctrl;
    logic [15:0] vchg;
    logic [15:0] status;
    logic aw_pend;
    logic w_pend;
    logic [31:0] awaddr;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    csu_axil_rsp_t rsp;
    csu_alert_st_t al;
    logic [TMR_W-1:0] tmr;
    csu_drv_t drv;
    logic [15:0] target;
    logic [15:0] dep_thr;
  } csu_st_t;

  csu_st_t st_q;
  csu_st_t st_d;
  logic bypass_qual;

  // Rounding down keeps the battery from seeing more than was asked for
  function automatic csu_vdec_t vdecode(input logic [15:0] v);
    csu_vdec_t r;
    r.target = v & ~VCHG_STEP_MASK;
    r.enable = 1'b1;
    r.out_of_range = 1'b0;
    if (v == VCHG_WAKE_MV) begin
      r.target = VCHG_WAKE_MV; // (R8)
    end else if (v >= VCHG_LO_MIN_MV && v <= VCHG_LO_MAX_MV) begin
      r.out_of_range = 1'b0; // (R5)
    end else if (v >= VCHG_HI_MIN_MV && v <= VCHG_HI_MAX_MV) begin
      r.out_of_range = 1'b0; // (R5)
    end else if (v > VCHG_HI_MAX_MV) begin
      r.target = VCHG_HI_MAX_MV; // (R6)
      r.out_of_range = 1'b1; // (R4)
    end else begin
      r.target = 16'h0000;
      r.enable = 1'b0; // (R7)
      r.out_of_range = 1'b1; // (R7)
    end
    return r;
  endfunction

  function automatic logic [15:0] wr16(input logic [15:0] old, input logic [31:0] d, input logic [3:0] be);
    logic [15:0] r;
    r = old;
    if (be[0]) begin
      r[7:0] = d[7:0];
    end
    if (be[1]) begin
      r[15:8] = d[15:8];
    end
    return r;
  endfunction

  function automatic logic [15:0] dep_calc(input logic [15:0] ctrl, input logic [15:0] target);
    logic [15:0] per_cell;
    per_cell = DEP_BASE_MV + 16'(ctrl[CTRL_DEP_LSB +: CTRL_DEP_W] * DEP_STEP_MV);
    return 16'(per_cell * ((target >= VCHG_HI_MIN_MV) ? CELLS_HI : CELLS_LO)); // (R2)
  endfunction

  csu_deglitch #(
    .CYC(DEGLITCH_CYC)
  ) u_bypass_dgl (
    .aclk(aclk),
    .aresetn(aresetn),
    .level(st_q.s2.input_margin_high),
    .qual(bypass_qual)
  );

  always_comb begin
    csu_vdec_t vd;
    logic por;
    logic [15:0] flags;
    logic toggle;
    logic stat_rd;
    logic adet;
    logic dep;
    logic learn;
    vd = vdecode(st_q.vchg);
    por = st_q.s2.adapter_wake & st_q.s2.supply_ok;
    flags = 16'h0000;
    toggle = 1'b0;
    stat_rd = 1'b0;
    adet = st_q.s2.adapter_detected;
    dep = st_q.s2.battery_depleted;
    learn = st_q.ctrl[CTRL_LEARN_BIT];
    st_d = st_q;
    st_d.s1 = cmp_i;
    st_d.s2 = st_q.s1;

    flags[STAT_DEP_BIT] = dep; // (R1)
    flags[STAT_VOR_BIT] = vd.out_of_range; // (R4)
    flags[STAT_REV_BIT] = st_q.s2.battery_above_adapter; // (R9)
    flags[STAT_BAT_BIT] = st_q.s2.battery_present; // (R11)
    flags[STAT_AC_BIT] = adet; // (R13)
    st_d.status = flags;
    toggle = (flags != st_q.status);

    if (st_q.rsp.bvalid && s_axi_req.bready) begin
      st_d.rsp.bvalid = 1'b0;
    end
    if (s_axi_req.awvalid && st_q.rsp.awready) begin
      st_d.aw_pend = 1'b1;
      st_d.awaddr = s_axi_req.awaddr;
    end
    if (s_axi_req.wvalid && st_q.rsp.wready) begin
      st_d.w_pend = 1'b1;
      st_d.wdata = s_axi_req.wdata;
      st_d.wstrb = s_axi_req.wstrb;
    end
    if (st_d.aw_pend && st_d.w_pend) begin
      st_d.aw_pend = 1'b0;
      st_d.w_pend = 1'b0;
      st_d.rsp.bvalid = 1'b1;
      st_d.rsp.bresp = RESP_OKAY;
      if (!por) begin
        st_d.rsp.bresp = RESP_SLVERR; // (R15)
      end else if (st_d.awaddr == ADDR_CTRL) begin
        st_d.ctrl = wr16(st_q.ctrl, st_d.wdata, st_d.wstrb);
      end else if (st_d.awaddr == ADDR_VCHG) begin
        st_d.vchg = wr16(st_q.vchg, st_d.wdata, st_d.wstrb);
      end else if (st_d.awaddr != ADDR_STAT) begin
        st_d.rsp.bresp = RESP_SLVERR;
      end
    end
    st_d.rsp.awready = !st_d.aw_pend && !st_d.rsp.bvalid;
    st_d.rsp.wready = !st_d.w_pend && !st_d.rsp.bvalid;

    if (st_q.rsp.rvalid && s_axi_req.rready) begin
      st_d.rsp.rvalid = 1'b0;
    end
    if (s_axi_req.arvalid && st_q.rsp.arready) begin
      st_d.rsp.rvalid = 1'b1;
      st_d.rsp.rresp = RESP_OKAY;
      st_d.rsp.rdata = 32'h00000000;
      if (!por) begin
        st_d.rsp.rresp = RESP_SLVERR; // (R15)
      end else if (s_axi_req.araddr == ADDR_CTRL) begin
        st_d.rsp.rdata = {16'h0000, st_q.ctrl};
      end else if (s_axi_req.araddr == ADDR_STAT) begin
        st_d.rsp.rdata = {16'h0000, st_q.status}; // (R17)
        stat_rd = 1'b1;
      end else if (s_axi_req.araddr == ADDR_VCHG) begin
        st_d.rsp.rdata = {16'h0000, st_q.vchg};
      end else begin
        st_d.rsp.rresp = RESP_SLVERR;
      end
    end
    st_d.rsp.arready = !st_d.rsp.rvalid;

    // Settings are held in reset until the supplies are up
    if (!por) begin
      st_d.ctrl = CTRL_RST; // (R15)
      st_d.vchg = VCHG_RST; // (R15)
    end

    // A toggle in the same cycle as the clearing read restarts the delay, so it is not lost
    unique case (st_q.al)
      AL_IDLE: begin
        if (toggle) begin
          st_d.al = AL_WAIT; // (R16)
          st_d.tmr = '0;
        end
      end
      AL_WAIT: begin
        if (st_q.tmr == TMR_W'(ALERT_CYC - 1)) begin
          st_d.al = AL_ON;
          st_d.drv.alert = 1'b1; // (R16)
        end else begin
          st_d.tmr = st_q.tmr + TMR_W'(1);
        end
      end
      AL_ON: begin
        if (stat_rd) begin
          st_d.drv.alert = 1'b0;
          st_d.tmr = '0;
          st_d.al = toggle ? AL_WAIT : AL_IDLE;
        end
      end
      default: begin
        st_d.al = AL_IDLE;
        st_d.drv.alert = 1'b0;
        st_d.tmr = '0;
      end
    endcase

    st_d.drv.battery_switch_drive = !dep; // (R3)
    st_d.drv.adapter_switch_drive = adet && (!learn || dep); // (R3)
    st_d.drv.bypass_switch_drive = adet && !st_q.s2.input_margin_low &&
                                   (st_q.drv.bypass_switch_drive || bypass_qual); // (R10)
    st_d.drv.charge_enable = por && adet && st_q.s2.battery_present && vd.enable; // (R12)
    st_d.drv.five_volt_reference_output = adet; // (R14)
    st_d.drv.gate_drive_regulator = por; // (R15)
    st_d.target = vd.target;
    st_d.dep_thr = dep_calc(st_q.ctrl, vd.target); // (R2)
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_q <= '0;
      st_q.rsp.awready <= 1'b1;
      st_q.rsp.wready <= 1'b1;
      st_q.rsp.arready <= 1'b1;
      st_q.al <= AL_IDLE;
    end else begin
      st_q <= st_d;
    end
  end

  assign s_axi_rsp = st_q.rsp;
  assign drv_o = st_q.drv;
  assign charge_target_mv = st_q.target;
  assign battery_depleted_threshold = st_q.dep_thr;

  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);

  logic past_valid_q;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      past_valid_q <= 1'b0;
    end else begin
      past_valid_q <= 1'b1;
    end
  end

  a_dep_flag: assert property (past_valid_q ##3 1 |-> st_q.status[STAT_DEP_BIT] == $past(cmp_i.battery_depleted, 3)) // (R1)
    else $error("depleted flag does not follow comparator");
  a_dep_cells: assert property ($stable(st_q.ctrl) && $stable(st_q.target) && past_valid_q
                                |-> st_q.dep_thr == dep_calc(st_q.ctrl, st_q.target)) // (R2)
    else $error("depleted threshold not scaled by cell count");
  a_batsw_off: assert property (st_q.status[STAT_DEP_BIT] |-> !st_q.drv.battery_switch_drive) // (R3)
    else $error("battery switch on while depleted");
  a_acsw_learn: assert property (st_q.status[STAT_DEP_BIT] && st_q.status[STAT_AC_BIT] && $past(st_q.ctrl[CTRL_LEARN_BIT])
                                 |-> st_q.drv.adapter_switch_drive) // (R3)
    else $error("adapter switch not taken over from depleted battery");
  a_vor_range: assert property ($stable(st_q.vchg) && (st_q.vchg < VCHG_LO_MIN_MV) && (st_q.vchg != VCHG_WAKE_MV)
                                |=> st_q.status[STAT_VOR_BIT]) // (R4)
    else $error("low setting not flagged out of range");
  a_step_trunc: assert property (st_q.target != VCHG_WAKE_MV |-> (st_q.target & VCHG_STEP_MASK) == 16'h0000) // (R5)
    else $error("target not rounded to converter step");
  a_vmax_clamp: assert property ($past(st_q.vchg) > VCHG_HI_MAX_MV |-> st_q.target == VCHG_HI_MAX_MV) // (R6)
    else $error("high setting not clamped to maximum");
  a_vor_disable: assert property (st_q.status[STAT_VOR_BIT] && st_q.target != VCHG_HI_MAX_MV
                                  |-> !st_q.drv.charge_enable) // (R7)
    else $error("charging on with bad voltage setting");
  a_wake_volt: assert property ($past(st_q.vchg) == VCHG_WAKE_MV |-> st_q.target == VCHG_WAKE_MV) // (R8)
    else $error("wake code not regulated to 9 V");
  a_rev_flag: assert property (past_valid_q ##3 1 |-> st_q.status[STAT_REV_BIT] == $past(cmp_i.battery_above_adapter, 3)) // (R9)
    else $error("reverse flag does not follow comparator");
  a_bypass_cut: assert property ($past(st_q.s2.input_margin_low) |-> !st_q.drv.bypass_switch_drive) // (R10)
    else $error("bypass not cut on low margin");
  a_bypass_qual: assert property ($rose(st_q.drv.bypass_switch_drive) |-> $past(bypass_qual)) // (R10)
    else $error("bypass turned on without deglitch");
  a_batt_flag: assert property (past_valid_q ##3 1 |-> st_q.status[STAT_BAT_BIT] == $past(cmp_i.battery_present, 3)) // (R11)
    else $error("battery flag does not follow comparator");
  a_nobatt_stop: assert property (!st_q.status[STAT_BAT_BIT] |-> !st_q.drv.charge_enable) // (R12)
    else $error("charging without battery");
  a_ac_flag: assert property (past_valid_q ##3 1 |-> st_q.status[STAT_AC_BIT] == $past(cmp_i.adapter_detected, 3)) // (R13)
    else $error("adapter flag does not follow comparator");
  a_noac_block: assert property (!st_q.status[STAT_AC_BIT] |-> !st_q.drv.charge_enable &&
                                 !st_q.drv.five_volt_reference_output) // (R14)
    else $error("charge or reference on without adapter");
  a_por_gate: assert property ($rose(st_q.rsp.bvalid) && !st_q.drv.gate_drive_regulator
                               |-> st_q.rsp.bresp == RESP_SLVERR) // (R15)
    else $error("write accepted before power-on");
  a_alert_delay: assert property ($rose(st_q.drv.alert) |-> $past(st_q.al) == AL_WAIT &&
                                  $past(st_q.tmr) == TMR_W'(ALERT_CYC - 1)) // (R16)
    else $error("alert raised at wrong delay");
  a_alert_start: assert property (st_q.al == AL_IDLE && st_d.status != st_q.status |=> st_q.al == AL_WAIT) // (R16)
    else $error("status toggle did not start alert delay");
  a_status_read: assert property ($rose(st_q.rsp.rvalid) && $past(s_axi_req.araddr) == ADDR_STAT &&
                                  st_q.drv.gate_drive_regulator
                                  |-> st_q.rsp.rdata == {16'h0000, $past(st_q.status)}) // (R17)
    else $error("status read does not return current flags");

  c_alert_seen: cover property ($rose(st_q.drv.alert));
  c_bypass_on: cover property ($rose(st_q.drv.bypass_switch_drive));
  c_charge_on: cover property ($rose(st_q.drv.charge_enable));
  c_write_done: cover property ($rose(st_q.rsp.bvalid) && st_q.rsp.bresp == RESP_OKAY);

endmodule

// [sim/csu_host_model.sv]
// AXI4-Lite host model that drives the charger status registers
`timescale 1ns/1ps
module csu_host_model (
  input wire logic aclk,
  output csu_pkg::csu_axil_req_t req,
  input csu_pkg::csu_axil_rsp_t rsp
);
  import csu_pkg::*;
  initial req = '0;
  // Each channel holds its payload until its own ready; the payload is scrambled once released
  task automatic wr(input logic [31:0] a, input logic [15:0] d, output logic [1:0] r);
    req.awaddr <= a;
    req.wdata <= {16'h0000, d};
    req.wstrb <= 4'h3;
    req.awvalid <= 1'b1;
    req.wvalid <= 1'b1;
    req.bready <= 1'b1;
    forever begin
      @(posedge aclk);
      if (req.awvalid && rsp.awready) begin
        req.awvalid <= 1'b0;
        req.awaddr <= ~a;
      end
      if (req.wvalid && rsp.wready) begin
        req.wvalid <= 1'b0;
        req.wdata <= ~{16'h0000, d};
      end
      // Response ready stays high between calls so a back-to-back call never reassigns it in one step
      if (rsp.bvalid) begin
        r = rsp.bresp;
        break;
      end
    end
  endtask
  task automatic rd(input logic [31:0] a, output logic [31:0] d, output logic [1:0] r);
    req.araddr <= a;
    req.arvalid <= 1'b1;
    req.rready <= 1'b1;
    forever begin
      @(posedge aclk);
      if (req.arvalid && rsp.arready) begin
        req.arvalid <= 1'b0;
        req.araddr <= ~a;
      end
      if (rsp.rvalid) begin
        d = rsp.rdata;
        r = rsp.rresp;
        break;
      end
    end
  endtask
endmodule

// [sim/csu_flags_tb_top.sv]
// Self-checking bench for the charger status flags block
`timescale 1ns/1ps
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin fails++; $display("[FAIL] %0t got %h exp %h", $time, a, b); end end
module csu_flags_tb_top;
  import csu_pkg::*;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  csu_axil_req_t req;
  csu_axil_rsp_t rsp;
  csu_cmp_t cmp = '0;
  csu_drv_t drv;
  logic [15:0] tgt;
  logic [15:0] thr;
  logic [31:0] d;
  logic [1:0] r;
  int fails = 0;
  int n_checks = 0;
  int cyc_n = 0;
  always #2 aclk = ~aclk;
  // Short windows keep the run small; expectations below follow these values
  csu_flags #(.DEGLITCH_CYC(16), .ALERT_CYC(20)) dut_u (.aclk(aclk), .aresetn(aresetn), .s_axi_req(req),
    .s_axi_rsp(rsp), .cmp_i(cmp), .drv_o(drv), .charge_target_mv(tgt), .battery_depleted_threshold(thr));
  csu_host_model host_u (.aclk(aclk), .req(req), .rsp(rsp));
  task automatic cyc(input int n);
    repeat (n) @(posedge aclk);
  endtask
  task automatic stat(input logic [4:0] e);
    host_u.rd(ADDR_STAT, d, r);
    `CHK(d[15:11], e)
  endtask
  task automatic t_unpowered;
    host_u.wr(ADDR_CTRL, 16'h0610, r);
    `CHK(r, RESP_SLVERR)
    `CHK(drv.gate_drive_regulator, 1'b0)
    `CHK(drv.five_volt_reference_output, 1'b0)
    $display("test unpowered done");
  endtask
  task automatic t_power;
    cmp <= 8'b0001_1111;
    cyc(40);
    `CHK(drv.gate_drive_regulator, 1'b1)
    `CHK(drv.five_volt_reference_output, 1'b1)
    `CHK(drv.charge_enable, 1'b0)
    stat(5'b11010);
    $display("test power done");
  endtask
  task automatic t_volt;
    logic [15:0] v[6] = '{16'h2328, 16'h3039, 16'h3A98, 16'h4E20, 16'h2710, 16'h4B00};
    logic [15:0] t[6] = '{16'h2328, 16'h3030, 16'h0000, 16'h4B00, 16'h0000, 16'h4B00};
    logic [5:0] en = 6'b110101;
    logic [5:0] oor = 6'b001110;
    for (int i = 0; i < 6; i++) begin
      host_u.wr(ADDR_VCHG, v[i], r);
      cyc(3);
      `CHK(tgt, t[i])
      `CHK(drv.charge_enable, en[5-i])
      stat({3'b110, oor[5-i], 1'b0});
    end
    // Learn bit set and three steps above the per-cell base
    host_u.wr(ADDR_CTRL, 16'h0610, r);
    cyc(4);
    `CHK(thr, 16'h3070)
    host_u.wr(ADDR_VCHG, 16'h3039, r);
    cyc(4);
    `CHK(thr, 16'h2454)
    $display("test voltage done");
  endtask
  task automatic t_depleted;
    `CHK(drv.adapter_switch_drive, 1'b0)
    `CHK(drv.battery_switch_drive, 1'b1)
    cmp.battery_depleted <= 1'b1;
    cyc(5);
    `CHK(drv.battery_switch_drive, 1'b0)
    `CHK(drv.adapter_switch_drive, 1'b1)
    stat(5'b11001);
    cmp.battery_depleted <= 1'b0;
    cmp.battery_present <= 1'b0;
    cyc(5);
    `CHK(drv.charge_enable, 1'b0)
    stat(5'b10000);
    cmp.battery_present <= 1'b1;
    cyc(5);
    `CHK(drv.charge_enable, 1'b1)
    $display("test depleted done");
  endtask
  task automatic t_bypass;
    `CHK(drv.bypass_switch_drive, 1'b1)
    cmp.battery_above_adapter <= 1'b1;
    cmp.input_margin_low <= 1'b1;
    cmp.input_margin_high <= 1'b0;
    cyc(6);
    `CHK(drv.bypass_switch_drive, 1'b0)
    stat(5'b11100);
    cmp.battery_above_adapter <= 1'b0;
    cmp.input_margin_low <= 1'b0;
    cmp.input_margin_high <= 1'b1;
    cyc(8);
    `CHK(drv.bypass_switch_drive, 1'b0)
    cyc(20);
    `CHK(drv.bypass_switch_drive, 1'b1)
    $display("test bypass done");
  endtask
  task automatic t_alert;
    cyc(30);
    `CHK(drv.alert, 1'b1)
    host_u.rd(ADDR_STAT, d, r);
    cyc(1);
    `CHK(drv.alert, 1'b0)
    cmp.battery_above_adapter <= 1'b1;
    cyc(12);
    `CHK(drv.alert, 1'b0)
    cyc(18);
    `CHK(drv.alert, 1'b1)
    $display("test alert done");
  endtask
  task automatic t_regs;
    host_u.wr(ADDR_STAT, 16'h0000, r);
    `CHK(r, RESP_OKAY)
    stat(5'b11100);
    host_u.rd(32'h0000_0050, d, r);
    `CHK(r, RESP_SLVERR)
    cmp.adapter_detected <= 1'b0;
    cyc(5);
    `CHK(drv.charge_enable, 1'b0)
    `CHK(drv.five_volt_reference_output, 1'b0)
    stat(5'b01100);
    $display("test registers done");
  endtask
  task automatic summarize;
    $display("checks %0d fails %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  // The whole sequence needs well under a thousand cycles
  always @(posedge aclk) begin
    cyc_n++;
    if (cyc_n == 20000) begin
      fails++;
      summarize();
    end
  end
  initial begin
    cyc(16);
    aresetn <= 1'b1;
    cyc(2);
    t_unpowered();
    t_power();
    t_volt();
    t_depleted();
    t_bypass();
    t_alert();
    t_regs();
    summarize();
  end
endmodule
